// ===== pkg/rig_map.svh
// Register offsets, field positions, reset values and timing figures of the interrupt gate
`ifndef RIG_MAP_SVH
`define RIG_MAP_SVH

`define RIG_ADDR_W 4
`define RIG_OFS_FLAG 4'hE
`define RIG_OFS_CTRL 4'hF

`define RIG_CTRL_CSEL_HI 7
`define RIG_CTRL_CSEL_LO 6
`define RIG_CTRL_UIE 5
`define RIG_CTRL_TIE 4
`define RIG_CTRL_AIE 3
`define RIG_CTRL_STOP 0
`define RIG_CSEL_RST 2'h1

`define RIG_FLAG_UF 5
`define RIG_FLAG_TF 4
`define RIG_FLAG_AF 3

`define RIG_CLK_HZ 100000000
`define RIG_TMR_REL_US 7800
`define RIG_UPD_SEC_REL_MS 500
`define RIG_UPD_MIN_REL_US 7800
`define RIG_CNT_W 26

`endif

// ===== pkg/rig_pkg.sv
// Types shared by the interrupt gate and stop control
package rig_pkg;
    typedef enum logic [1:0] {
        RIG_SRC_4096HZ,
        RIG_SRC_64HZ,
        RIG_SRC_SECOND,
        RIG_SRC_MINUTE
    } rig_tmr_src_t;
endpackage

// ===== hdl/rig_ctl.sv
// Interrupt gating, auto-release and stop control of the clock-calendar device
// Operation
// - Timer flag rise with enable drives interrupt
// - Timer enable low blocks and cancels assertion
// - Timer assertion self-releases within 7.8 ms
// - Alarm assertion held until alarm flag cleared
// - Alarm enable low blocks and cancels assertion
// - Interrupt output is OR of three requests
// - Writing stop one halts, clears sub-second count
// - Bus STOP/restart during timeout clears stop
// - Writing stop zero restarts calendar and timer
// - Stopped: no calendar updates, update, alarm events
// - Stopped timer runs only from 4096 Hz
// - Stopped: divider 2048 Hz to 1 Hz held
// - Reserved control bits ignore writes, read zero
// - Flags clear on zero write only
// - Update interrupt asserts, self-releases after interval
`include "rig_map.svh"
module rig_ctl #(
    parameter int TMR_REL_CYC = (`RIG_CLK_HZ / 1000000) * `RIG_TMR_REL_US,
    parameter int UPD_SEC_REL_CYC = (`RIG_CLK_HZ / 1000) * `RIG_UPD_SEC_REL_MS,
    parameter int UPD_MIN_REL_CYC = (`RIG_CLK_HZ / 1000000) * `RIG_UPD_MIN_REL_US
) (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic [`RIG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    output logic [7:0] reg_rdata_o,
    input wire logic update_evt_i,
    input wire logic timer_evt_i,
    input wire logic alarm_evt_i,
    input wire logic minute_update_sel_i,
    input wire rig_pkg::rig_tmr_src_t tmr_src_i,
    input wire logic bus_stop_rs_i,
    input wire logic bus_timeout_active_i,
    output logic int_out_o,
    output logic int_oe_o,
    output logic cal_halt_o,
    output logic div_rst_o,
    output logic subsec_clr_o,
    output logic tmr_count_en_o,
    output logic [1:0] csel_o
);
    import rig_pkg::*;

    logic [1:0] csel_ff;
    logic update_irq_en_ff;
    logic timer_irq_en_ff;
    logic alarm_irq_en_ff;
    logic stop_ff;
    logic update_event_flag_ff;
    logic timer_event_flag_ff;
    logic alarm_event_flag_ff;
    logic upd_pend_ff;
    logic tmr_pend_ff;
    logic [`RIG_CNT_W-1:0] upd_cnt_ff;
    logic [`RIG_CNT_W-1:0] tmr_cnt_ff;
    logic ctrl_wr;
    logic flag_wr;
    logic upd_evt;
    logic alm_evt;
    logic upd_expire;
    logic tmr_expire;
    logic [`RIG_CNT_W-1:0] upd_limit;
    logic irq_any;

    assign ctrl_wr = reg_wr_i && (reg_addr_i == `RIG_OFS_CTRL);
    assign flag_wr = reg_wr_i && (reg_addr_i == `RIG_OFS_FLAG);
    // Calendar-derived events are suppressed while stopped
    assign upd_evt = update_evt_i && !stop_ff;
    assign alm_evt = alarm_evt_i && !stop_ff;
    assign upd_limit = minute_update_sel_i ? `RIG_CNT_W'(UPD_MIN_REL_CYC - 1)
                                           : `RIG_CNT_W'(UPD_SEC_REL_CYC - 1);
    assign upd_expire = (upd_cnt_ff >= upd_limit);
    assign tmr_expire = (tmr_cnt_ff == `RIG_CNT_W'(TMR_REL_CYC - 1));

    // Control register; bits 2:1 have no storage
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            csel_ff <= `RIG_CSEL_RST;
            update_irq_en_ff <= 1'b0;
            timer_irq_en_ff <= 1'b0;
            alarm_irq_en_ff <= 1'b0;
        end else if (ctrl_wr) begin
            csel_ff <= reg_wdata_i[`RIG_CTRL_CSEL_HI:`RIG_CTRL_CSEL_LO];
            update_irq_en_ff <= reg_wdata_i[`RIG_CTRL_UIE];
            timer_irq_en_ff <= reg_wdata_i[`RIG_CTRL_TIE];
            alarm_irq_en_ff <= reg_wdata_i[`RIG_CTRL_AIE];
        end
    end

    // Stop bit: the bus safety clear wins over a write in the same cycle
    // Sub-second clear still pulses when a bus cancel blocks the same write
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            stop_ff <= 1'b0;
        end else if (bus_stop_rs_i && bus_timeout_active_i) begin
            stop_ff <= 1'b0;
        end else if (ctrl_wr) begin
            stop_ff <= reg_wdata_i[`RIG_CTRL_STOP];
        end
    end

    // Flags: an event in the clearing cycle keeps the flag set
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            update_event_flag_ff <= 1'b0;
            timer_event_flag_ff <= 1'b0;
            alarm_event_flag_ff <= 1'b0;
        end else begin
            if (upd_evt) begin
                update_event_flag_ff <= 1'b1;
            end else if (flag_wr && !reg_wdata_i[`RIG_FLAG_UF]) begin
                update_event_flag_ff <= 1'b0;
            end
            if (timer_evt_i) begin
                timer_event_flag_ff <= 1'b1;
            end else if (flag_wr && !reg_wdata_i[`RIG_FLAG_TF]) begin
                timer_event_flag_ff <= 1'b0;
            end
            if (alm_evt) begin
                alarm_event_flag_ff <= 1'b1;
            end else if (flag_wr && !reg_wdata_i[`RIG_FLAG_AF]) begin
                alarm_event_flag_ff <= 1'b0;
            end
        end
    end

    // Timer request: armed only by a 0-to-1 flag change with the enable set
    // Pin is freed one full interval after it first drives low
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            tmr_pend_ff <= 1'b0;
            tmr_cnt_ff <= '0;
        end else if (!timer_irq_en_ff) begin
            tmr_pend_ff <= 1'b0;
            tmr_cnt_ff <= '0;
        end else if (timer_evt_i && !timer_event_flag_ff) begin
            tmr_pend_ff <= 1'b1;
            tmr_cnt_ff <= '0;
        end else if (tmr_pend_ff) begin
            if (tmr_expire) begin
                tmr_pend_ff <= 1'b0;
            end else begin
                tmr_cnt_ff <= tmr_cnt_ff + `RIG_CNT_W'(1);
            end
        end
    end

    // Update request: same scheme, interval follows the update period
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            upd_pend_ff <= 1'b0;
            upd_cnt_ff <= '0;
        end else if (!update_irq_en_ff) begin
            upd_pend_ff <= 1'b0;
            upd_cnt_ff <= '0;
        end else if (upd_evt && !update_event_flag_ff) begin
            upd_pend_ff <= 1'b1;
            upd_cnt_ff <= '0;
        end else if (upd_pend_ff) begin
            if (upd_expire) begin
                upd_pend_ff <= 1'b0;
            end else begin
                upd_cnt_ff <= upd_cnt_ff + `RIG_CNT_W'(1);
            end
        end
    end

    // Alarm has no timer: it follows the flag, so only a flag clear or the alarm enable going low releases it
    assign irq_any = (upd_pend_ff && update_irq_en_ff)
                   || (tmr_pend_ff && timer_irq_en_ff)
                   || (alarm_event_flag_ff && alarm_irq_en_ff);

    // Open-drain pin: data is always low, the enable carries the request
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            int_out_o <= 1'b0;
            int_oe_o <= 1'b0;
        end else begin
            int_out_o <= 1'b0;
            int_oe_o <= irq_any;
        end
    end

    // Stop-related controls to the calendar, divider and timer
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            cal_halt_o <= 1'b0;
            div_rst_o <= 1'b0;
            subsec_clr_o <= 1'b0;
            tmr_count_en_o <= 1'b1;
            csel_o <= `RIG_CSEL_RST;
        end else begin
            cal_halt_o <= stop_ff;
            div_rst_o <= stop_ff;
            subsec_clr_o <= ctrl_wr && reg_wdata_i[`RIG_CTRL_STOP];
            tmr_count_en_o <= !stop_ff || (tmr_src_i == RIG_SRC_4096HZ);
            csel_o <= csel_ff;
        end
    end

    // Read data, one cycle after the address; unknown offsets read zero
    // Flag bits that this block does not hold read as zero
    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 8'h00;
        end else begin
            case (reg_addr_i)
                `RIG_OFS_CTRL: reg_rdata_o <= {csel_ff, update_irq_en_ff, timer_irq_en_ff,
                                              alarm_irq_en_ff, 2'h0, stop_ff};
                `RIG_OFS_FLAG: reg_rdata_o <= {2'h0, update_event_flag_ff, timer_event_flag_ff,
                                              alarm_event_flag_ff, 3'h0};
                default: reg_rdata_o <= 8'h00;
            endcase
        end
    end
endmodule

// ===== testbench/rig_ctl_asserts.sv
// Port-level checks of the interrupt gate and stop control
`include "rig_map.svh"
module rig_ctl_chk (
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    input wire logic reg_wr_i,
    input wire logic [`RIG_ADDR_W-1:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic [7:0] reg_rdata_o,
    input wire rig_pkg::rig_tmr_src_t tmr_src_i,
    input wire logic bus_stop_rs_i,
    input wire logic bus_timeout_active_i,
    input wire logic int_oe_o,
    input wire logic cal_halt_o,
    input wire logic div_rst_o,
    input wire logic subsec_clr_o,
    input wire logic tmr_count_en_o
);
    timeunit 1ns;
    timeprecision 1ns;
    import rig_pkg::*;
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);
    wire logic wr_c = reg_wr_i && reg_addr_i == `RIG_OFS_CTRL;
    // Bus cancel wins over a same-cycle write, so it is excluded below
    wire logic bclr = bus_stop_rs_i && bus_timeout_active_i;
    property p_halt; wr_c && reg_wdata_i[0] && !bclr |=> ##1 cal_halt_o && div_rst_o; endproperty
    a_halt: assert property (p_halt) else $error("stop write did not halt");
    property p_sclr; wr_c && reg_wdata_i[0] && !bclr |=> subsec_clr_o; endproperty
    a_sclr: assert property (p_sclr) else $error("no sub-second clear");
    property p_bclr; bclr |=> ##1 !cal_halt_o; endproperty
    a_bclr: assert property (p_bclr) else $error("bus cancel kept stop");
    property p_run; wr_c && !reg_wdata_i[0] |=> ##1 !cal_halt_o && tmr_count_en_o; endproperty
    a_run: assert property (p_run) else $error("stop clear did not restart");
    property p_div; div_rst_o == cal_halt_o; endproperty
    a_div: assert property (p_div) else $error("divider reset differs from halt");
    property p_cen; (cal_halt_o && tmr_src_i != RIG_SRC_4096HZ) [*2] |-> !tmr_count_en_o;
    endproperty
    a_cen: assert property (p_cen) else $error("timer counts while stopped");
    property p_rsv; $past(reg_addr_i) == `RIG_OFS_CTRL |-> reg_rdata_o[2:1] == 2'h0; endproperty
    a_rsv: assert property (p_rsv) else $error("reserved control bits not zero");
    property p_dis; wr_c && reg_wdata_i[5:3] == 3'h0 |=> ##1 !int_oe_o; endproperty
    a_dis: assert property (p_dis) else $error("interrupt kept with enables off");
endmodule
bind rig_ctl rig_ctl_chk u_chk (.ref_clk_i, .nrst_i, .reg_wr_i, .reg_addr_i, .reg_wdata_i,
    .reg_rdata_o, .tmr_src_i, .bus_stop_rs_i, .bus_timeout_active_i, .int_oe_o, .cal_halt_o,
    .div_rst_o, .subsec_clr_o, .tmr_count_en_o);

// ===== testbench/rig_host.sv
// Host model: register master that reads flags to find the interrupt cause
module rig_host (
    input wire logic ref_clk_i,
    input wire logic [7:0] reg_rdata_i,
    output logic reg_wr_o,
    output logic [3:0] reg_addr_o,
    output logic [7:0] reg_wdata_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        reg_wr_o = 1'h0;
        reg_addr_o = 4'h0;
        reg_wdata_o = 8'h00;
    end
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(negedge ref_clk_i);
        reg_wr_o = 1'h1;
        reg_addr_o = a;
        reg_wdata_o = d;
        @(negedge ref_clk_i);
        reg_wr_o = 1'h0;
        // Released data shows the inverse so a stale value cannot pass
        reg_wdata_o = ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(negedge ref_clk_i);
        reg_addr_o = a;
        @(negedge ref_clk_i);
        d = reg_rdata_i;
    endtask
    // Polling without the pin: enables off, then flags read
    task automatic poll(output logic [7:0] f);
        wr(4'hF, 8'h40);
        rd(4'hE, f);
    endtask
endmodule

// ===== testbench/rig_ctl_tb_top.sv
// Self-checking bench for the interrupt gate and stop control
`include "rig_map.svh"
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin fails++; \
    $display("Error %s exp %h got %h", n, e, g); end end
module rig_ctl_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import rig_pkg::*;
    localparam logic [3:0] CR = `RIG_OFS_CTRL;
    localparam logic [3:0] FR = `RIG_OFS_FLAG;
    logic clk, nrst, wr, upd, tmr, alm, msel, bstop, bto, io, oe, halt, drst, sclr, cen;
    logic [3:0] addr;
    logic [7:0] wd, rd, d;
    logic [1:0] csel;
    rig_tmr_src_t src;
    int fails, comparisons, n;
    rig_ctl #(.TMR_REL_CYC(20), .UPD_SEC_REL_CYC(40), .UPD_MIN_REL_CYC(20)) dut (
        .ref_clk_i(clk), .nrst_i(nrst), .reg_wr_i(wr), .reg_addr_i(addr), .reg_wdata_i(wd),
        .reg_rdata_o(rd), .update_evt_i(upd), .timer_evt_i(tmr), .alarm_evt_i(alm),
        .minute_update_sel_i(msel), .tmr_src_i(src), .bus_stop_rs_i(bstop),
        .bus_timeout_active_i(bto), .int_out_o(io), .int_oe_o(oe), .cal_halt_o(halt),
        .div_rst_o(drst), .subsec_clr_o(sclr), .tmr_count_en_o(cen), .csel_o(csel));
    rig_host host (.ref_clk_i(clk), .reg_rdata_i(rd), .reg_wr_o(wr), .reg_addr_o(addr),
        .reg_wdata_o(wd));
    initial begin
        clk = 1'h0;
        forever #5 clk = ~clk;
    end
    task automatic pulse(ref logic s);
        @(negedge clk);
        s = 1'h1;
        @(negedge clk);
        s = 1'h0;
    endtask
    task automatic w2();
        repeat (2) @(negedge clk);
    endtask
    task automatic hi_len();
        // Caller has seen two high samples, so the count starts at one
        n = 1;
        while (oe === 1'h1 && n < 100) begin
            @(negedge clk);
            n++;
        end
    endtask
    task automatic t_regs();
        host.rd(CR, d);
        `CHK("ctrl", 8'h40, d)
        host.wr(CR, 8'hFF);
        host.rd(CR, d);
        `CHK("ctrl", 8'hF9, d)
        `CHK("csel", 2'h3, csel)
        host.rd(4'h3, d);
        `CHK("unmapped", 8'h00, d)
        host.wr(CR, 8'h40);
    endtask
    task automatic t_timer();
        host.wr(CR, 8'h50);
        pulse(tmr);
        w2();
        `CHK("oe", 1'h1, oe)
        `CHK("int data", 1'h0, io)
        hi_len();
        `CHK("tmr len", 20, n)
        host.wr(FR, 8'hFF);
        host.rd(FR, d);
        `CHK("flags", 8'h10, d)
        pulse(tmr);
        w2();
        `CHK("oe", 1'h0, oe)
        host.wr(FR, 8'h00);
        pulse(tmr);
        w2();
        `CHK("oe", 1'h1, oe)
        host.wr(CR, 8'h40);
        w2();
        `CHK("oe", 1'h0, oe)
        host.wr(FR, 8'h00);
        pulse(tmr);
        w2();
        `CHK("oe", 1'h0, oe)
        host.wr(FR, 8'h00);
    endtask
    task automatic t_alarm();
        host.wr(CR, 8'h58);
        pulse(alm);
        pulse(tmr);
        repeat (40) @(negedge clk);
        `CHK("oe", 1'h1, oe)
        host.wr(FR, 8'h00);
        w2();
        `CHK("oe", 1'h0, oe)
        pulse(alm);
        w2();
        `CHK("oe", 1'h1, oe)
        host.wr(CR, 8'h40);
        w2();
        `CHK("oe", 1'h0, oe)
        host.wr(FR, 8'h00);
        pulse(alm);
        pulse(upd);
        pulse(tmr);
        w2();
        `CHK("oe", 1'h0, oe)
        host.poll(d);
        `CHK("flags", 8'h38, d)
        host.wr(FR, 8'h00);
    endtask
    task automatic t_update();
        host.wr(CR, 8'h60);
        for (int s = 0; s < 2; s++) begin
            msel = s[0];
            pulse(upd);
            w2();
            hi_len();
            `CHK("upd len", s ? 20 : 40, n)
            host.wr(FR, 8'h00);
        end
    endtask
    task automatic t_stop();
        host.wr(CR, 8'h69);
        `CHK("sub-second clear", 1'h1, sclr)
        w2();
        `CHK("halt", 1'h1, halt)
        `CHK("sub-second clear", 1'h0, sclr)
        `CHK("div rst", 1'h1, drst)
        for (int s = 0; s < 4; s++) begin
            src = rig_tmr_src_t'(s);
            w2();
            `CHK("cnt en", s == 0, cen)
        end
        pulse(upd);
        pulse(alm);
        host.rd(FR, d);
        `CHK("flags", 8'h00, d)
        pulse(bstop);
        w2();
        `CHK("halt", 1'h1, halt)
        bto = 1'h1;
        pulse(bstop);
        w2();
        `CHK("halt", 1'h0, halt)
        bto = 1'h0;
        host.wr(CR, 8'h41);
        host.wr(CR, 8'h40);
        w2();
        `CHK("cnt en", 1'h1, cen)
        `CHK("halt", 1'h0, halt)
    endtask
    task automatic stop_test();
        $display("Comparisons %0d, mismatches %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        {nrst, upd, tmr, alm, msel, bstop, bto} = 7'h00;
        src = RIG_SRC_4096HZ;
        repeat (4) @(negedge clk);
        nrst = 1'h1;
        t_regs();
        t_timer();
        t_alarm();
        t_update();
        t_stop();
        stop_test();
    end
    // Whole run is about 245 cycles; this span leaves wide margin
    initial begin
        #100000;
        fails++;
        stop_test();
    end
endmodule
